// [design/psau_unit.sv]
// pack status word and latched alarm logic with open-drain interrupt line
// assumes synchronous register strobes from the serial-bus front end and
// event pulses from measurement, timer and protection blocks on clk
`include "psau_defines.svh"

module psau_unit
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  // register access
  input  wire psau_pkg::psau_reg_req_t regReq,
  output logic [15:0]                 regRdData,
  output logic                        regRdValid,
  // device events and control
  input  wire psau_pkg::psau_events_t evt,
  input  wire psau_pkg::psau_ctrl_t   ctrl,
  // charger detector pin
  input  wire logic                   chargerDetectPin,
  // interrupt line, open drain
  output logic                        irqOut,
  output logic                        irqOe,
  // status to the rest of the device
  output logic                        autonomousFetMode,
  output logic                        sleepAllowed,
  output logic                        configEditActive
);
  import psau_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [15:0] latched_q;
  logic [15:0] mask_q;
  logic        fetMode_q;
  logic        fullReset_q;
  logic        sleepOk_q;
  logic        cfgEdit_q;
  logic        maskLoaded_q;
  logic [2:0]  cdSync_q;
  logic        cdDebounced_q;
  logic        cdLatched_q;
  logic        irqLine_q;
  logic [15:0] raw;
  logic [15:0] latched_d;
  logic [15:0] statusWord;
  logic        cfgExit;
  logic        wrLatched;
  logic        wrMask;

  // one offset compare shared by both write decoders
  function automatic logic regHit(input psau_reg_req_t r, input logic [7:0] ofs);
    regHit = r.addr == ofs;
  endfunction

  // decoded strobes; an exit only counts while editing
  assign cfgExit   = ctrl.exitConfigEditCmd && cfgEdit_q;
  assign wrLatched = regReq.wrStrobe && regHit(regReq, `PSAU_OFS_ALARM_LATCHED);
  assign wrMask    = regReq.wrStrobe && regHit(regReq, `PSAU_OFS_ALARM_MASK);

  // ----------------------------------------
  // charger detector: three stages, change counts when last two agree
  // ----------------------------------------
  // stage one may be metastable, so only stage two reads it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cdSync_q      <= 3'h0;
      cdDebounced_q <= 1'b0;
    end
    else
    begin
      cdSync_q <= {cdSync_q[1:0], chargerDetectPin};
      if (cdSync_q[2] == cdSync_q[1])
      begin
        cdDebounced_q <= cdSync_q[2];
      end
    end
  end

  // ----------------------------------------
  // raw alarm sources
  // ----------------------------------------
  always_comb
  begin
    raw                       = 16'h0000;
    raw[`PSAU_AL_FAULT_A]     = |evt.faultA;
    raw[`PSAU_AL_FAULT_B]     = |evt.faultB;
    raw[`PSAU_AL_WARN_A]      = |evt.warnA;
    raw[`PSAU_AL_WARN_B]      = |evt.warnB;
    raw[`PSAU_AL_CHG_OFF]     = !evt.chargeDriverOn;
    raw[`PSAU_AL_DSG_OFF]     = !evt.dischargeDriverOn;
    raw[`PSAU_AL_SHUTDOWN_VOLTAGE_SRC]       = evt.stackBelowShut || evt.cellBelowShut;
    raw[`PSAU_AL_BAL]         = evt.balancingActive;
    raw[`PSAU_AL_FULLLOOP]    = evt.fullLoopPulse;
    raw[`PSAU_AL_SCAN]        = evt.scanCompletePulse;
    raw[`PSAU_AL_WAKE]        = evt.wakePulse;
    raw[`PSAU_AL_SLEEP]       = evt.sleepEntryPulse;
    raw[`PSAU_AL_TIMER]       = evt.timerExpiryPulse;
    raw[`PSAU_AL_STARTUP]     = evt.startupDonePulse;
    // raw bit is the synchronised pin, ahead of the debounce
    raw[`PSAU_AL_CHGDET]      = cdSync_q[2];
    raw[`PSAU_AL_FULLRESET]   = fullReset_q;
  end

  // ----------------------------------------
  // latched flags: set wins over a same-cycle clear
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_flag
      logic setBit;
      logic clrBit;
      if (gi == `PSAU_AL_CHGDET)
      begin : g_cd
        assign setBit = mask_q[gi] && (cdDebounced_q != cdLatched_q);
      end
      else
      begin : g_src
        assign setBit = mask_q[gi] && raw[gi];
      end
      assign clrBit = wrLatched && regReq.wrData[gi];
      assign latched_d[gi] = setBit ? 1'b1 : (clrBit ? 1'b0 : latched_q[gi]);
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latched_q <= `PSAU_RST_WORD;
    end
    else
    begin
      latched_q <= latched_d;
    end
  end

  // detector state last taken into the flag logic
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cdLatched_q <= 1'b0;
    end
    else if (mask_q[`PSAU_AL_CHGDET])
    begin
      cdLatched_q <= cdDebounced_q;
    end
  end

  // ----------------------------------------
  // alarm mask: stored default loaded once after reset
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_q       <= `PSAU_RST_WORD;
      maskLoaded_q <= 1'b0;
    end
    else
    begin
      maskLoaded_q <= 1'b1;
      // a host write in the load cycle wins over the stored default
      if (wrMask)
      begin
        mask_q <= regReq.wrData;
      end
      else if (!maskLoaded_q)
      begin
        mask_q <= ctrl.storedAlarmMask;
      end
    end
  end

  // ----------------------------------------
  // pack status control bits
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfgEdit_q <= 1'b0;
    end
    // entry beats a same-cycle exit
    else if (ctrl.enterConfigEditCmd)
    begin
      cfgEdit_q <= 1'b1;
    end
    else if (cfgExit)
    begin
      cfgEdit_q <= 1'b0;
    end
  end

  // full reset flag: reset is the only way in
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fullReset_q <= 1'b1;
    end
    else if (cfgExit)
    begin
      fullReset_q <= 1'b0;
    end
  end

  // stored options are taken late, so the first edge loads them
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fetMode_q <= 1'b0;
    end
    else if (cfgExit || !maskLoaded_q)
    begin
      fetMode_q <= ctrl.storedFetMode;
    end
    else if (ctrl.autonomousFetToggleCmd)
    begin
      fetMode_q <= !fetMode_q;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sleepOk_q <= 1'b0;
    end
    else if (!maskLoaded_q)
    begin
      sleepOk_q <= ctrl.storedSleepOk;
    end
    // allow beats a same-cycle forbid
    else if (ctrl.sleepAllowCmd)
    begin
      sleepOk_q <= 1'b1;
    end
    else if (ctrl.sleepForbidCmd)
    begin
      sleepOk_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // interrupt line
  // ----------------------------------------
  // registered from the next flags so the pin cannot glitch low
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irqLine_q <= 1'b0;
    end
    else
    begin
      irqLine_q <= |latched_d;
    end
  end

  assign irqOut = 1'b0;
  assign irqOe  = irqLine_q;

  // ----------------------------------------
  // status word and register reads
  // ----------------------------------------
  always_comb
  begin
    statusWord                     = 16'h0000;
    statusWord[`PSAU_ST_FET_MODE]  = fetMode_q;
    statusWord[`PSAU_ST_FULL_RESET] = fullReset_q;
    statusWord[`PSAU_ST_SLEEP_OK]  = sleepOk_q;
    statusWord[`PSAU_ST_CFG_EDIT]  = cfgEdit_q;
    statusWord[`PSAU_ST_IRQ_LINE]  = irqLine_q;
    statusWord[`PSAU_ST_CHG_ON]    = evt.chargeDriverOn;
    statusWord[`PSAU_ST_DSG_ON]    = evt.dischargeDriverOn;
    statusWord[`PSAU_ST_CHGDET]    = cdDebounced_q;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdValid <= 1'b0;
    end
    else
    begin
      regRdValid <= regReq.rdStrobe;
    end
  end

  // unmapped offsets read zero; data holds until the next read
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      regRdData <= 16'h0000;
    end
    else if (regReq.rdStrobe)
    begin
      case (regReq.addr)
        `PSAU_OFS_PACK_STATUS:   regRdData <= statusWord;
        `PSAU_OFS_ALARM_LATCHED: regRdData <= latched_q;
        `PSAU_OFS_ALARM_RAW:     regRdData <= raw;
        `PSAU_OFS_ALARM_MASK:    regRdData <= mask_q;
        default:                 regRdData <= 16'h0000;
      endcase
    end
  end

  // outputs for sleep, fet and config-edit logic elsewhere
  assign autonomousFetMode = fetMode_q;
  assign sleepAllowed      = sleepOk_q;
  assign configEditActive  = cfgEdit_q;

endmodule

// [shared/psau_defines.svh]
// register offsets, bit positions and reset values of the pack status and alarm unit
// assumes the includer is one of the unit's own files
`ifndef PSAU_DEFINES_SVH
`define PSAU_DEFINES_SVH

// ----------------------------------------
// command offsets
// ----------------------------------------
`define PSAU_OFS_PACK_STATUS   8'h12
`define PSAU_OFS_ALARM_LATCHED 8'h62
`define PSAU_OFS_ALARM_RAW     8'h64
`define PSAU_OFS_ALARM_MASK    8'h66

// ----------------------------------------
// pack status word bit positions
// ----------------------------------------
`define PSAU_ST_FET_MODE   8
`define PSAU_ST_FULL_RESET 7
`define PSAU_ST_SLEEP_OK   6
`define PSAU_ST_CFG_EDIT   5
`define PSAU_ST_IRQ_LINE   4
`define PSAU_ST_CHG_ON     3
`define PSAU_ST_DSG_ON     2
`define PSAU_ST_CHGDET     1

// ----------------------------------------
// alarm bit positions (raw, latched and mask share them)
// ----------------------------------------
`define PSAU_AL_FAULT_A   15
`define PSAU_AL_FAULT_B   14
`define PSAU_AL_WARN_A    13
`define PSAU_AL_WARN_B    12
`define PSAU_AL_CHG_OFF   11
`define PSAU_AL_DSG_OFF   10
`define PSAU_AL_SHUTDOWN_VOLTAGE_SRC     9
`define PSAU_AL_BAL       8
`define PSAU_AL_FULLLOOP  7
`define PSAU_AL_SCAN      6
`define PSAU_AL_WAKE      5
`define PSAU_AL_SLEEP     4
`define PSAU_AL_TIMER     3
`define PSAU_AL_STARTUP   2
`define PSAU_AL_CHGDET    1
`define PSAU_AL_FULLRESET 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define PSAU_RST_WORD 16'h0000

`endif

// [shared/psau_pkg.sv]
// types of the pack status and alarm unit
// assumes psau_defines.svh sits beside it
package psau_pkg;

  // ----------------------------------------
  // register access port
  // ----------------------------------------
  typedef struct packed {
    logic        wrStrobe;
    logic        rdStrobe;
    logic [7:0]  addr;
    logic [15:0] wrData;
  } psau_reg_req_t;

  // ----------------------------------------
  // events and levels from the rest of the device
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] faultA;
    logic [15:0] faultB;
    logic [15:0] warnA;
    logic [15:0] warnB;
    logic        chargeDriverOn;
    logic        dischargeDriverOn;
    logic        stackBelowShut;
    logic        cellBelowShut;
    logic        balancingActive;
    logic        scanCompletePulse;
    logic        fullLoopPulse;
    logic        sleepEntryPulse;
    logic        wakePulse;
    logic        timerExpiryPulse;
    logic        startupDonePulse;
  } psau_events_t;

  // ----------------------------------------
  // stored defaults and subcommands
  // ----------------------------------------
  typedef struct packed {
    logic        storedFetMode;
    logic        storedSleepOk;
    logic [15:0] storedAlarmMask;
    logic        enterConfigEditCmd;
    logic        exitConfigEditCmd;
    logic        autonomousFetToggleCmd;
    logic        sleepAllowCmd;
    logic        sleepForbidCmd;
  } psau_ctrl_t;

endpackage

// [verif/psau_unit_monitor.sv]
// concurrent checks on the ports of the pack status and alarm unit
// assumes psau_pkg is compiled first and the unit is bound below
module psau_unit_monitor
(
  // clock and reset
  input wire logic                    clk,
  input wire logic                    reset_n,
  // register access
  input wire psau_pkg::psau_reg_req_t regReq,
  input wire logic [15:0]             regRdData,
  input wire logic                    regRdValid,
  // control and status
  input wire psau_pkg::psau_ctrl_t    ctrl,
  input wire logic                    irqOut,
  input wire logic                    irqOe,
  input wire logic                    autonomousFetMode,
  input wire logic                    sleepAllowed,
  input wire logic                    configEditActive
);
  timeunit 1ns;
  timeprecision 1ns;
  import psau_pkg::*;
  logic porModel_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // full-reset flag kept beside the unit: set by reset, cleared leaving edit
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      porModel_q <= 1'b1;
    end
    else if (configEditActive && ctrl.exitConfigEditCmd)
    begin
      porModel_q <= 1'b0;
    end
  end

  // ------
  // checks
  // ------
  AST_EDIT_ENTER: assert property (ctrl.enterConfigEditCmd |=> configEditActive)
    else $error("edit entry not shown");
  AST_EDIT_HOLD: assert property (!configEditActive && !ctrl.enterConfigEditCmd
    |=> !configEditActive) else $error("edit set without entry");
  AST_EDIT_EXIT: assert property (configEditActive && ctrl.exitConfigEditCmd
    && !ctrl.enterConfigEditCmd |=> !configEditActive) else $error("edit not left");
  AST_FET_LOAD: assert property (configEditActive && ctrl.exitConfigEditCmd
    && !ctrl.enterConfigEditCmd && !ctrl.autonomousFetToggleCmd
    |=> autonomousFetMode == $past(ctrl.storedFetMode)) else $error("fet default lost");
  // first edge after reset loads defaults, so commands there are skipped
  AST_FET_TOGGLE: assert property ($past(reset_n) && ctrl.autonomousFetToggleCmd
    && !(configEditActive && ctrl.exitConfigEditCmd)
    |=> autonomousFetMode != $past(autonomousFetMode)) else $error("fet mode not toggled");
  AST_SLEEP_ALLOW: assert property ($past(reset_n) && ctrl.sleepAllowCmd
    |=> sleepAllowed) else $error("sleep not allowed");
  AST_SLEEP_FORBID: assert property ($past(reset_n) && ctrl.sleepForbidCmd
    && !ctrl.sleepAllowCmd |=> !sleepAllowed) else $error("sleep not forbidden");
  AST_IRQ_OR: assert property (regRdValid && $past(regReq.addr) == 8'h62
    |-> $past(irqOe) == (|regRdData)) else $error("line not or of flags");
  AST_STATUS_MIRROR: assert property (regRdValid && $past(regReq.addr) == 8'h12
    |-> regRdData[8:4] == {$past(autonomousFetMode), $past(porModel_q), $past(sleepAllowed),
    $past(configEditActive), $past(irqOe)}) else $error("status word mismatch");
  AST_STATUS_RSVD: assert property (regRdValid && $past(regReq.addr) == 8'h12
    |-> regRdData[15:9] == 7'h00 && !regRdData[0]) else $error("reserved bit set");
  AST_IRQ_DRIVE: assert property (!irqOut)
    else $error("open-drain data high");
endmodule

bind psau_unit psau_unit_monitor u_mon
(
  .clk(clk), .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData),
  .regRdValid(regRdValid), .ctrl(ctrl), .irqOut(irqOut), .irqOe(irqOe),
  .autonomousFetMode(autonomousFetMode), .sleepAllowed(sleepAllowed),
  .configEditActive(configEditActive)
);

// [verif/psau_host_model.sv]
// host side: register master and pulled-up interrupt wire
// assumes reads answer one cycle after the strobe edge
module psau_host_model
(
  // clock
  input  wire logic                 clk,
  // register access
  output psau_pkg::psau_reg_req_t   regReq,
  input  wire logic [15:0]          regRdData,
  input  wire logic                 regRdValid,
  // interrupt wire
  input  wire logic                 irqOut,
  input  wire logic                 irqOe,
  output logic                      irqLine
);
  timeunit 1ns;
  timeprecision 1ns;
  import psau_pkg::*;
  // pull-up holds the wire high unless the unit sinks it
  assign irqLine = irqOe ? irqOut : 1'b1;
  initial regReq = '0;

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    regReq <= '0;
  endtask

  // a missing answer returns unknown so the compare fails
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    regReq <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    regReq <= '0;
    @(posedge clk);
    d = regRdValid ? regRdData : 'x;
  endtask
endmodule

// [verif/psau_unit_tb_top.sv]
// self-checking bench of the pack status and alarm unit
// assumes unit, checker and host model are compiled before it
module psau_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import psau_pkg::*;
  logic          clk = 1'b0;
  logic          reset_n = 1'b0;
  psau_reg_req_t regReq;
  logic [15:0]   regRdData;
  logic          regRdValid;
  psau_events_t  evt = '{chargeDriverOn: 1'b1, dischargeDriverOn: 1'b1, default: '0};
  psau_ctrl_t    ctrl = '{1'b1, 1'b0, 16'h0021, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  logic          chargerDetectPin = 1'b0;
  logic          irqOut, irqOe, irqLine, fetMode, sleepOk, cfgEdit;
  int            miscompares = 0;
  int            nChecks = 0;
  int            cyc = 0;
  always #5 clk = ~clk;

  psau_unit dut (.clk(clk), .reset_n(reset_n), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .evt(evt), .ctrl(ctrl), .chargerDetectPin(chargerDetectPin),
    .irqOut(irqOut), .irqOe(irqOe), .autonomousFetMode(fetMode), .sleepAllowed(sleepOk),
    .configEditActive(cfgEdit));
  psau_host_model host (.clk(clk), .regReq(regReq), .regRdData(regRdData),
    .regRdValid(regRdValid), .irqOut(irqOut), .irqOe(irqOe), .irqLine(irqLine));

  // ------
  // helpers
  // ------
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    nChecks++;
    if (g !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] v;
    host.rd(a, v);
    cmp(v, e);
  endtask
  task automatic finish_test();
    if (miscompares == 0 && nChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_reset();
    chk(8'h66, 16'h0021);
    chk(8'h12, 16'h019C);
    chk(8'h64, 16'h0001);
    chk(8'h62, 16'h0001);
    cmp({15'h0000, irqLine}, 16'h0000);
  endtask
  task automatic t_edit();
    @(posedge clk) ctrl.enterConfigEditCmd <= 1'b1;
    @(posedge clk) ctrl.enterConfigEditCmd <= 1'b0;
    chk(8'h12, 16'h01BC);
    @(posedge clk) ctrl.sleepAllowCmd <= 1'b1;
    @(posedge clk) ctrl.sleepAllowCmd <= 1'b0;
    ctrl.exitConfigEditCmd <= 1'b1;
    @(posedge clk) ctrl.exitConfigEditCmd <= 1'b0;
    ctrl.autonomousFetToggleCmd <= 1'b1;
    @(posedge clk) ctrl.autonomousFetToggleCmd <= 1'b0;
    chk(8'h12, 16'h005C);
    host.wr(8'h62, 16'h0001);
    chk(8'h62, 16'h0000);
    cmp({15'h0000, irqLine}, 16'h0001);
    @(posedge clk) ctrl.sleepForbidCmd <= 1'b1;
    @(posedge clk) ctrl.sleepForbidCmd <= 1'b0;
    chk(8'h12, 16'h000C);
  endtask
  // all six momentary sources sit in evt[5:0]
  task automatic t_pulse();
    host.wr(8'h66, 16'h0054);
    @(posedge clk) evt[5:0] <= 6'h3F;
    @(posedge clk) evt[5:0] <= 6'h00;
    chk(8'h64, 16'h0000);
    chk(8'h62, 16'h0054);
    host.wr(8'h66, 16'h00A8);
    @(posedge clk) evt[5:0] <= 6'h3F;
    @(posedge clk) evt[5:0] <= 6'h00;
    chk(8'h62, 16'h00FC);
    host.wr(8'h62, 16'h0000);
    chk(8'h62, 16'h00FC);
    host.wr(8'h62, 16'h00A8);
    chk(8'h62, 16'h0054);
    host.wr(8'h62, 16'h0054);
    chk(8'h62, 16'h0000);
  endtask
  task automatic t_level();
    host.wr(8'h66, 16'hFF00);
    @(posedge clk) evt <= '{16'h0100, 16'h0001, 16'h8000, 16'h0002, 1'b0, 1'b0, 1'b0, 1'b1,
      1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    chk(8'h64, 16'hFF00);
    chk(8'h62, 16'hFF00);
    @(posedge clk) evt <= '{chargeDriverOn: 1'b1, dischargeDriverOn: 1'b1, default: '0};
    host.wr(8'h62, 16'hFFFF);
    chk(8'h62, 16'h0000);
  endtask
  task automatic t_charger();
    host.wr(8'h66, 16'h0002);
    @(posedge clk) chargerDetectPin <= 1'b1;
    repeat (8) @(posedge clk);
    chk(8'h64, 16'h0002);
    chk(8'h62, 16'h0002);
    chk(8'h12, 16'h001E);
    host.wr(8'h62, 16'h0002);
    @(posedge clk) chargerDetectPin <= 1'b0;
    repeat (8) @(posedge clk);
    chk(8'h62, 16'h0002);
    chk(8'h64, 16'h0000);
  endtask
  // a second reset in mid-run raises the full-reset flag again
  task automatic t_rereset();
    @(posedge clk) reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk(8'h12, 16'h019C);
    chk(8'h62, 16'h0001);
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      miscompares++;
      finish_test();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_edit();
    t_pulse();
    t_level();
    t_charger();
    t_rereset();
    finish_test();
  end
endmodule
